// ===== rtl/rsw_pkg.sv
// Purpose: constants for the reset supervisor and watchdog block
// Assumes: 40 MHz clock, internal time base tick derived by a divider
// Notes:   windows and stretch counted in time base ticks
package rsw_pkg;
  // -----------------------------------------------------------------
  // clock and time base
  // -----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 40000000;
  localparam int unsigned TICK_US          = 1000;
  localparam int unsigned TICK_CYCLES      = CLK_HZ / 1000000 * TICK_US;
  // -----------------------------------------------------------------
  // timing in ticks of one millisecond
  // -----------------------------------------------------------------
  localparam int unsigned STRETCH_MS       = 1120;
  localparam int unsigned STARTUP_MS       = 35000;
  localparam int unsigned NORMAL_MS        = 1120;
  localparam int unsigned STRETCH_TICKS    = (STRETCH_MS * 1000 + TICK_US - 1)
                                             / TICK_US;
  localparam int unsigned STARTUP_TICKS    = (STARTUP_MS * 1000 + TICK_US - 1)
                                             / TICK_US;
  localparam int unsigned NORMAL_TICKS     = (NORMAL_MS * 1000 + TICK_US - 1)
                                             / TICK_US;
  localparam int unsigned CNT_W            = 32;
endpackage : rsw_pkg

// ===== rtl/rsw_top.sv
// Purpose: reset supervisor with watchdog, stretched active-low resets
// Assumes: comparator results arrive as synchronous logic levels
// Notes:   all timing counted on a one-cycle time base tick
`timescale 1ns/1ps

// What this block does
// - secondary reset low while either supply is low or manual reset low
// - secondary reset held one stretch period after all its causes clear
// - manual reset low forces reset, stretched after it returns high
// - no kick within active window expires watchdog, primary reset for one stretch
// - watchdog counter clears on reset and on every kick edge
// - long startup window applies after every reset event
// - first kick after reset switches to the shorter normal window
// - watchdog disabled while the kick input is detected unconnected
// - primary reset asserts while aux comparator reports undervoltage
// - primary reset on any cause, stretched after each cause clears
// - any cause returning during stretch restarts the stretch from zero
// - active-high reset output is the complement of primary reset
module rsw_top #(
  parameter int unsigned TICK_CYC  = rsw_pkg::TICK_CYCLES,
  parameter int unsigned STRETCH_T = rsw_pkg::STRETCH_TICKS,
  parameter int unsigned STARTUP_T = rsw_pkg::STARTUP_TICKS,
  parameter int unsigned NORMAL_T  = rsw_pkg::NORMAL_TICKS
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic primary_supply_low,
  input  wire logic secondary_supply_low,
  input  wire logic aux_undervoltage_in,
  input  wire logic manual_reset_n,
  input  wire logic watchdog_kick_in,
  input  wire logic kick_unconnected,
  output logic      primary_reset_n,
  output logic      primary_reset,
  output logic      secondary_reset_n
);
  localparam int W = rsw_pkg::CNT_W;

  // -----------------------------------------------------------------
  // time base divider
  // -----------------------------------------------------------------
  logic [W-1:0] div_r;
  logic         tick_r;
  wire          div_end = (div_r == W'(TICK_CYC - 1));

  // free-running divider, one-cycle tick
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r  <= div_end ? '0 : div_r + 1'b1;
      tick_r <= div_end;
    end

  // -----------------------------------------------------------------
  // input sampling on the time base
  // -----------------------------------------------------------------
  logic [1:0] kick_s_r;
  logic [1:0] mr_s_r;

  // two stages on tick, edge taken between them
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      kick_s_r <= 2'h0;
      mr_s_r   <= 2'h3;
    end
    else if (tick_r)
    begin
      kick_s_r <= {kick_s_r[0], watchdog_kick_in};
      mr_s_r   <= {mr_s_r[0], manual_reset_n};
    end

  wire kick_edge = tick_r && (kick_s_r[0] ^ kick_s_r[1]);
  wire mr_low    = !mr_s_r[1];

  // -----------------------------------------------------------------
  // cause decode
  // -----------------------------------------------------------------
  logic wd_exp_r;
  wire  sec_cause = primary_supply_low || secondary_supply_low
                    || mr_low;
  wire  pri_cause = sec_cause || aux_undervoltage_in
                    || wd_exp_r;

  // -----------------------------------------------------------------
  // stretch counters
  // -----------------------------------------------------------------
  logic [W-1:0] pri_cnt_r;
  logic [W-1:0] sec_cnt_r;
  wire          pri_busy = pri_cause || (pri_cnt_r != '0);
  wire          sec_busy = sec_cause || (sec_cnt_r != '0);

  // reload while a cause stands, count down on tick after
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      pri_cnt_r <= W'(STRETCH_T);
      sec_cnt_r <= W'(STRETCH_T);
    end
    else
    begin
      if (pri_cause)
        pri_cnt_r <= W'(STRETCH_T);
      else if (tick_r && pri_cnt_r != '0)
        pri_cnt_r <= pri_cnt_r - 1'b1;
      if (sec_cause)
        sec_cnt_r <= W'(STRETCH_T);
      else if (tick_r && sec_cnt_r != '0)
        sec_cnt_r <= sec_cnt_r - 1'b1;
    end

  // -----------------------------------------------------------------
  // watchdog
  // -----------------------------------------------------------------
  logic [W-1:0] wd_cnt_r;
  logic         wd_normal_r;
  wire [W-1:0]  wd_limit = wd_normal_r ? W'(NORMAL_T)
                                       : W'(STARTUP_T);
  wire          wd_hit   = tick_r && !kick_edge && !pri_busy
                           && !kick_unconnected
                           && (wd_cnt_r + 1'b1 >= wd_limit);

  // counter, window select and expiry pulse into the reset chain
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      wd_cnt_r    <= '0;
      wd_normal_r <= 1'b0;
      wd_exp_r    <= 1'b0;
    end
    else
    begin
      wd_exp_r <= wd_hit;
      if (pri_busy || kick_unconnected)
      begin
        wd_cnt_r <= '0;
        if (pri_busy)
          wd_normal_r <= 1'b0;
      end
      else if (kick_edge)
      begin
        wd_cnt_r    <= '0;
        wd_normal_r <= 1'b1;
      end
      else if (wd_hit)
        wd_cnt_r <= '0;
      else if (tick_r)
        wd_cnt_r <= wd_cnt_r + 1'b1;
    end

  // -----------------------------------------------------------------
  // output registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      primary_reset_n   <= 1'b0;
      primary_reset     <= 1'b1;
      secondary_reset_n <= 1'b0;
    end
    else
    begin
      primary_reset_n   <= !pri_busy;
      primary_reset     <= pri_busy;
      secondary_reset_n <= !sec_busy;
    end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_pri_cause;
    pri_cause;
  endsequence

  // expiry tick followed by the registered pulse into the reset chain
  sequence s_wd_fire;
    wd_hit ##1 wd_exp_r;
  endsequence

  a_sec_low_cause: assert property (
    @(posedge clk) disable iff (sys_rst)
    sec_cause |=> !secondary_reset_n)
    else $error("secondary reset not low on cause");
  a_pri_low_aux: assert property (
    @(posedge clk) disable iff (sys_rst)
    aux_undervoltage_in |=> !primary_reset_n)
    else $error("primary reset not low on aux undervoltage");
  a_pri_stretch: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_pri_cause ##1 !pri_cause |=> !primary_reset_n)
    else $error("primary reset released without stretch");
  a_pri_restart: assert property (
    @(posedge clk) disable iff (sys_rst)
    pri_cause |=> pri_cnt_r == W'(STRETCH_T))
    else $error("stretch not restarted");
  a_high_compl: assert property (
    @(posedge clk) disable iff (sys_rst)
    primary_reset == !primary_reset_n)
    else $error("active-high reset not complement");
  // a kick while the pin reads unconnected may leave the window as it was
  a_wd_clear_kick: assert property (
    @(posedge clk) disable iff (sys_rst)
    kick_edge |=> wd_cnt_r == '0
      && (wd_normal_r == !$past(pri_busy) || $past(kick_unconnected)))
    else $error("watchdog not cleared on kick");
  a_wd_expire: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_wd_fire |=> !primary_reset_n)
    else $error("expiry did not reset");
  a_wd_disable: assert property (
    @(posedge clk) disable iff (sys_rst)
    kick_unconnected && $past(kick_unconnected)
      |-> !wd_exp_r && wd_cnt_r == '0)
    else $error("watchdog fired while disabled");
  a_wd_startup: assert property (
    @(posedge clk) disable iff (sys_rst)
    pri_busy |=> !wd_normal_r)
    else $error("startup window not reapplied");
  a_mr_sec: assert property (
    @(posedge clk) disable iff (sys_rst)
    mr_low |=> !secondary_reset_n && !primary_reset_n)
    else $error("manual reset not forcing reset");
endmodule : rsw_top

// ===== verif/rsw_cpu_model.sv
// Purpose: processor model that kicks the watchdog input
// Assumes: the processor makes no kicks while it is held in reset
// Notes:   a kick toggles the line every 12 clocks, 3 time base ticks
`timescale 1ns/1ps
module rsw_cpu_model (
  input  wire logic clk,
  input  wire logic primary_reset_n,
  input  wire logic kick_en,
  output logic      watchdog_kick_in
);
  int unsigned cnt_r = 0;
  initial watchdog_kick_in = 1'h0;
  // toggle periodically while running, hold the level otherwise
  always @(posedge clk)
  begin
    if (kick_en && primary_reset_n)
    begin
      cnt_r <= (cnt_r == 11) ? 0 : cnt_r + 1;
      if (cnt_r == 11)
        watchdog_kick_in <= ~watchdog_kick_in;
    end
  end
endmodule : rsw_cpu_model

// ===== verif/tb_rsw_top.sv
// Purpose: self-checking bench for the reset supervisor and watchdog
// Assumes: tick of 4 clocks, stretch 5, startup 20, normal 8 ticks
// Notes:   release times are checked against windows in clocks
`timescale 1ns/1ps
module tb_rsw_top;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic primary_supply_low = 1'h0;
  logic secondary_supply_low = 1'h0;
  logic aux_undervoltage_in = 1'h0;
  logic manual_reset_n = 1'h1;
  logic kick_unconnected = 1'h1;
  logic kick_en = 1'h0;
  logic watchdog_kick_in;
  logic primary_reset_n;
  logic primary_reset;
  logic secondary_reset_n;
  int   n_errors = 0;
  int   compares = 0;
  int   cycles = 0;
  rsw_top #(.TICK_CYC(4), .STRETCH_T(5), .STARTUP_T(20), .NORMAL_T(8))
    rsw_top_inst (.clk(clk), .sys_rst(sys_rst),
    .primary_supply_low(primary_supply_low),
    .secondary_supply_low(secondary_supply_low),
    .aux_undervoltage_in(aux_undervoltage_in),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
    .kick_unconnected(kick_unconnected), .primary_reset_n(primary_reset_n),
    .primary_reset(primary_reset), .secondary_reset_n(secondary_reset_n));
  rsw_cpu_model rsw_cpu_model_inst (.clk(clk), .kick_en(kick_en),
    .primary_reset_n(primary_reset_n), .watchdog_kick_in(watchdog_kick_in));
  // clock and hang guard
  initial forever #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // wait for primary reset to reach lvl, inside lo..hi clocks
  task automatic wait_lvl(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (primary_reset_n !== lvl && n <= hi);
    chk(n >= lo && n <= hi, 1);
  endtask : wait_lvl
  // primary reset must stay high on every one of len clocks
  task automatic hold_hi(input int len);
    int lows;
    lows = 0;
    repeat (len)
    begin
      @(posedge clk);
      #1;
      if (primary_reset_n !== 1'h1)
        lows++;
    end
    chk(lows, 0);
  endtask : hold_hi
  // cause 0 primary, 1 secondary, 2 aux, 3 manual, held len+1 clocks
  task automatic pulse(input int sel, input int len);
    @(posedge clk);
    primary_supply_low <= (sel == 0);
    secondary_supply_low <= (sel == 1);
    aux_undervoltage_in <= (sel == 2);
    manual_reset_n <= (sel != 3);
    repeat (len) @(posedge clk);
    #1;
    chk(primary_reset_n, 0);
    chk(secondary_reset_n, sel == 2);
    chk(primary_reset, 1);
    @(posedge clk);
    {primary_supply_low, secondary_supply_low, aux_undervoltage_in} <= 3'h0;
    manual_reset_n <= 1'h1;
  endtask : pulse
  task automatic t_causes();
    for (int s = 0; s < 4; s++)
    begin
      pulse(s, 16);
      wait_lvl(1, 16, s == 3 ? 44 : 32);
      repeat (4) @(posedge clk);
      #1;
      chk({secondary_reset_n, primary_reset}, 2'h2);
    end
    pulse(0, 5);
    repeat (12) @(posedge clk);
    pulse(1, 3);
    wait_lvl(1, 16, 32);
    hold_hi(150);
    $display("test causes done");
  endtask : t_causes
  task automatic t_watchdog();
    @(posedge clk);
    kick_unconnected <= 1'h0;
    pulse(0, 4);
    wait_lvl(1, 16, 32);
    wait_lvl(0, 76, 100);
    chk(secondary_reset_n, 1);
    wait_lvl(1, 16, 32);
    @(posedge clk);
    kick_en <= 1'h1;
    hold_hi(200);
    @(posedge clk);
    kick_en <= 1'h0;
    wait_lvl(0, 16, 56);
    wait_lvl(1, 16, 32);
    // an expiry is a reset event, so the long window comes back
    wait_lvl(0, 76, 100);
    wait_lvl(1, 16, 32);
    @(posedge clk);
    kick_unconnected <= 1'h1;
    hold_hi(150);
    $display("test watchdog done");
  endtask : t_watchdog
  task automatic final_report();
    $display("counts: compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    #1;
    chk({primary_reset_n, primary_reset}, 2'h1);
    chk(secondary_reset_n, 0);
    wait_lvl(1, 16, 32);
    $display("test power up done");
    t_causes();
    t_watchdog();
    final_report();
  end
endmodule : tb_rsw_top
